// ---- core/flow_noise_filter.sv ----
// What this block does
// RULE1: measure amplitude at four noise probe frequencies
// RULE2: low band noise is mean of two probes
// RULE3: at 5 Hz flag noise unless 25x margin
// RULE4: same check around 37.5 Hz band
// RULE5: coil drive is 5 Hz or 37 Hz
// RULE6: auto-zero runs alone, busy for 90 s
// RULE7: host triggers auto-zero only at 37 Hz
// RULE8: filter mode forces 37 Hz and defaults
// RULE9: processing off or 5 Hz leaves filter mode
// RULE10: enabled output is running average of inputs
// RULE11: one input per tenth second, window of count
// RULE12: sample count 1 to 125, default 90
// RULE13: band around average accepts, else scrutinise
// RULE14: percent limit 0 to 100, default 2
// RULE15: time limit restarts average at new flow
// RULE16: time limit 0.6 to 256 s, default 2
// RULE17: band edges are average plus/minus average*pct/100
// RULE18: lone outlier held, output keeps average
// RULE19: held value dropped if next is in band
// RULE20: same-side follower adds held value to average
// RULE21: noise flag clears when check passes again
// RULE22: settings apply at next sample, average intact; a new count or processing off restarts the window here
`include "fnf_regs.svh"
`default_nettype none
module flow_noise_filter
  import fnf_pkg::*;
#(
  parameter logic [31:0] TICK_CYCLES = 32'(`FNF_TICK_CYCLES),
  parameter logic [31:0] AZ_CYCLES = 32'(`FNF_AZ_CYCLES)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [8:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic regRvalid,
  input wire fnf_flow_t sampleIn,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire fnf_amp_t amp,
  input wire logic ampValid,
  output fnf_flow_t flowOut,
  output logic flowOutValid,
  output logic highNoise,
  output logic coilRateHigh,
  output logic autoZeroBusy
);
  // window storage is sized for the longest count setting
  localparam int WIN = 125;  // deepest window the count allows

  // host-visible settings and the copy in use by the qualifier
  fnf_rate_t rate;
  logic dspOn;  // signal processing switch
  logic filterMode;  // 1 = filter, 0 = normal
  fnf_cfg_t cfgW;  // as written by the host
  fnf_cfg_t cfgA;  // as used since the last increment
  logic enA;
  // cycles spent in the current auto-zero
  logic [31:0] azCnt;

  // sample increment timebase
  // a small TICK_CYCLES keeps simulation short; the default gives 0.1 s
  logic [31:0] tickCnt;
  logic tick;

  // qualifier state
  fnf_state_t state;
  fnf_flow_t x;  // input under evaluation
  fnf_flow_t win [WIN];  // running average window
  // ring position and number of entries in use
  logic [6:0] wrPtr;
  logic [6:0] fill;
  // 40 bits: 125 full-scale samples cannot overflow the sum
  logic signed [39:0] sum;
  // one outlier is parked here while its follower is judged
  logic held;
  fnf_flow_t heldVal;
  logic heldAbove;  // direction of held value
  // cleared whenever an input lands inside the band
  logic [11:0] outCnt;  // increments spent out of band

  // fifo drain side
  fnf_flow_t fifoData;
  logic fifoValid;
  logic fifoPop;

  // one-bit enum, so the compare is just the rate register
  assign coilRateHigh = rate == FNF_RATE_HIGH;
  // pop only when the qualifier is free to take the sample
  assign fifoPop = state == FNF_IDLE && tick;

  // input buffer: samples wait here until their increment comes round
  fnf_fifo #(
    .WIDTH(32),
    .DEPTH(8)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .inData(sampleIn),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  // tenth-second tick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tickCnt <= '0;
      tick <= 1'b0;
    end else begin
      // one-cycle pulse at the end of each increment
      tick <= tickCnt == TICK_CYCLES - 32'h0000_0001;  // [RULE11]
      tickCnt <= (tickCnt == TICK_CYCLES - 32'h0000_0001) ? '0 : tickCnt + 32'h0000_0001;
    end
  end

  // host writes to settings; out-of-range values are ignored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rate <= FNF_RATE_LOW;
      dspOn <= 1'b0;
      filterMode <= 1'b0;
      cfgW <= '{count: `FNF_SAMPLES_DEF, pct: `FNF_PCT_DEF, tlim: `FNF_TLIM_DEF};
    end else if (regWrite) begin
      unique case (regAddr)
        `FNF_REG_COIL: begin
          rate <= fnf_rate_t'(regWdata[`FNF_BIT_ON]);  // [RULE5]
          // dropping to 5 Hz also drops filter mode
          if (!regWdata[`FNF_BIT_ON]) filterMode <= 1'b0;  // [RULE9]
        end
        `FNF_REG_ENABLE: begin
          dspOn <= regWdata[`FNF_BIT_ON];
          // switching processing off also drops filter mode
          if (!regWdata[`FNF_BIT_ON]) filterMode <= 1'b0;  // [RULE9]
        end
        `FNF_REG_MODE: begin
          // writing 0 only returns to normal mode
          filterMode <= regWdata[`FNF_BIT_ON];
          if (regWdata[`FNF_BIT_ON]) begin
            // filter mode brings its own coil rate and defaults
            rate <= FNF_RATE_HIGH;  // [RULE8]
            dspOn <= 1'b1;  // [RULE8]
            cfgW <= '{count: `FNF_SAMPLES_DEF, pct: `FNF_PCT_DEF,
                      tlim: `FNF_TLIM_DEF};  // [RULE8]
          end
        end
        `FNF_REG_SAMPLES: begin
          // out-of-range counts keep the old setting
          if (regWdata >= 16'(`FNF_SAMPLES_MIN) && regWdata <= 16'(`FNF_SAMPLES_MAX))
            cfgW.count <= regWdata[6:0];  // [RULE12]
        end
        `FNF_REG_PCT_LO: begin
          // the value lives in the low word of the pair
          if (regWdata <= 16'(`FNF_PCT_MAX)) cfgW.pct <= regWdata[6:0];  // [RULE14]
        end
        `FNF_REG_TLIM_LO: begin
          // held in tenths of a second
          if (regWdata >= 16'(`FNF_TLIM_MIN) && regWdata <= 16'(`FNF_TLIM_MAX))
            cfgW.tlim <= regWdata[11:0];  // [RULE16]
        end
        default: begin
          // high words and unmapped numbers take no write
        end
      endcase
    end
  end

  // auto-zero: once triggered it ignores further triggers until done
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      azCnt <= '0;
      autoZeroBusy <= 1'b0;
    end else if (autoZeroBusy) begin
      // triggers arriving now are ignored
      azCnt <= azCnt + 32'h0000_0001;
      if (azCnt == AZ_CYCLES - 32'h0000_0001) autoZeroBusy <= 1'b0;  // [RULE6]
    end else if (regWrite && regAddr == `FNF_REG_AUTOZERO && regWdata[`FNF_BIT_ON]) begin
      // rate is not checked here; picking 37 Hz first is the host's job
      azCnt <= '0;
      autoZeroBusy <= 1'b1;  // [RULE6]
    end
  end

  // register reads, answered one cycle later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdata <= '0;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      // data stands one cycle, then drops back to zero
      regRdata <= '0;
      if (regRead) begin
        unique case (regAddr)
          `FNF_REG_COIL: regRdata <= {15'h0000, coilRateHigh};
          `FNF_REG_ENABLE: regRdata <= {15'h0000, dspOn};
          `FNF_REG_MODE: regRdata <= {15'h0000, filterMode};
          `FNF_REG_SAMPLES: regRdata <= {9'h000, cfgW.count};
          `FNF_REG_PCT_LO: regRdata <= {9'h000, cfgW.pct};
          `FNF_REG_TLIM_LO: regRdata <= {4'h0, cfgW.tlim};
          default: regRdata <= '0;
        endcase
      end
    end
  end

  // noise diagnostic: compare 2*signal with ratio*(sum of probes),
  // avoiding the divide that a true mean would need
  // 24 bits hold 25 times the sum of two 16-bit probes
  logic [23:0] noise5;
  logic [23:0] noise37;
  logic fail5;
  logic fail37;
  assign noise5 = `FNF_NOISE_RATIO * 24'({amp.probe2p5} + {amp.probe7p5});  // [RULE2]
  assign noise37 = `FNF_NOISE_RATIO * 24'({amp.probe32p5} + {amp.probe42p5});  // [RULE4]
  assign fail5 = {7'h00, amp.sig5, 1'b0} < noise5;  // [RULE3]
  assign fail37 = {7'h00, amp.sig37p5, 1'b0} < noise37;  // [RULE4]

  // flag follows each fresh set of amplitudes, so it drops on a pass
  always_ff @(posedge clock or posedge rst) begin
    if (rst) highNoise <= 1'b0;
    else if (ampValid) highNoise <= coilRateHigh ? fail37 : fail5;  // [RULE1] [RULE3] [RULE21]
  end

  // band around the current average
  // width uses the magnitude of the average, so it never goes negative
  fnf_flow_t avgNow;
  logic [32:0] absAvg;
  logic [39:0] dev;
  logic signed [40:0] upper;
  logic signed [40:0] lower;
  logic above;
  logic below;
  logic winFull;
  logic timeout;
  logic [6:0] nextPtr;
  assign avgNow = (fill == '0) ? x : 32'(sum / $signed({33'h0_0000_0000, fill}));  // [RULE10]
  assign absAvg = avgNow[31] ? 33'(-$signed({avgNow[31], avgNow})) : {1'b0, avgNow};
  assign dev = 40'(absAvg * cfgA.pct) / `FNF_PCT_DIV;  // [RULE17]
  assign upper = 41'(avgNow) + $signed({1'b0, dev});  // [RULE17]
  assign lower = 41'(avgNow) - $signed({1'b0, dev});  // [RULE17]
  assign above = 41'(x) > upper;  // [RULE13]
  assign below = 41'(x) < lower;  // [RULE13]
  assign winFull = fill == cfgA.count;
  // limit reached when this increment would be tlim spent out of band
  assign timeout = held && ({outCnt + 12'h001} >= cfgA.tlim);  // [RULE15]
  // the ring wraps at the set count, not at the array size
  assign nextPtr = (wrPtr + 7'h01 == cfgA.count) ? 7'h00 : wrPtr + 7'h01;

  // qualifier sequence: take a sample, judge it, publish the output
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= FNF_IDLE;
      x <= '0;
      cfgA <= '{count: `FNF_SAMPLES_DEF, pct: `FNF_PCT_DEF, tlim: `FNF_TLIM_DEF};
      enA <= 1'b0;
      wrPtr <= '0;
      fill <= '0;
      sum <= '0;
      held <= 1'b0;
      heldVal <= '0;
      heldAbove <= 1'b0;
      outCnt <= '0;
      flowOut <= '0;
      flowOutValid <= 1'b0;
    end else begin
      flowOutValid <= 1'b0;
      unique case (state)
        FNF_IDLE: begin
          if (tick) begin
            // settings copied only between samples
            cfgA <= cfgW;  // [RULE22]
            enA <= dspOn;
            // a new length or a disable starts the window afresh, so no
            // stale entry is counted at the wrong weight
            if (cfgW.count != cfgA.count || !dspOn) begin  // [RULE22]
              wrPtr <= '0;
              fill <= '0;
              sum <= '0;
              held <= 1'b0;
              outCnt <= '0;
            end
            // an empty buffer simply skips this increment
            if (fifoValid) begin
              x <= fifoData;  // [RULE11]
              state <= FNF_EVAL;
            end
          end
        end
        FNF_EVAL: begin
          state <= FNF_PUBLISH;
          if (!enA) begin
            // raw path, nothing to keep
          end else if (fill == '0 || (!above && !below)) begin
            // good input, and any held spike is thrown away
            held <= 1'b0;  // [RULE19]
            outCnt <= '0;
            win[wrPtr] <= x;  // [RULE10]
            // the oldest entry leaves once the window is full
            sum <= sum + 40'(x) - (winFull ? 40'(win[wrPtr]) : 40'h00_0000_0000);
            if (!winFull) fill <= fill + 7'h01;
            wrPtr <= nextPtr;
          end else if (timeout) begin
            // real change lasted the limit: restart at the new value
            win[0] <= x;  // [RULE15]
            sum <= 40'(x);  // [RULE15]
            fill <= 7'h01;
            wrPtr <= (cfgA.count == 7'h01) ? 7'h00 : 7'h01;
            held <= 1'b0;
            outCnt <= '0;
          end else if (held && heldAbove == above) begin
            // second outlier on the same side: held one joins the average
            win[wrPtr] <= heldVal;  // [RULE20]
            sum <= sum + 40'(heldVal) - (winFull ? 40'(win[wrPtr]) : 40'h00_0000_0000);
            if (!winFull) fill <= fill + 7'h01;
            wrPtr <= nextPtr;
            heldVal <= x;
            outCnt <= outCnt + 12'h001;
          end else begin
            // lone outlier, or side flipped: hold it and wait
            held <= 1'b1;  // [RULE18]
            heldVal <= x;
            heldAbove <= above;
            outCnt <= held ? outCnt + 12'h001 : 12'h001;
          end
        end
        FNF_PUBLISH: begin
          // running average goes out while enabled, else the raw input
          flowOut <= enA ? avgNow : x;  // [RULE10] [RULE18]
          flowOutValid <= 1'b1;
          state <= FNF_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- core/fnf_fifo.sv ----
`default_nettype none
module fnf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr];
  assign outValid = count != '0;
  always_comb begin
    next_count = count;
    if (push && !pop) next_count = count + 1'b1;
    else if (pop && !push) next_count = count - 1'b1;
  end
  // pointers and fill; ready is registered so the source sees a clean level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b1;
    end else begin
      if (push) wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      if (pop) rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      count <= next_count;
      inReady <= next_count != (AW + 1)'(DEPTH);
    end
  end
  // data store
  always_ff @(posedge clock) begin
    if (push) mem[wrPtr] <= inData;
  end
endmodule
`default_nettype wire

// ---- core/fnf_pkg.sv ----
`default_nettype none
package fnf_pkg;
  // one flow sample, signed
  typedef logic signed [31:0] fnf_flow_t;
  // spectral amplitudes around both coil bands
  typedef struct packed {
    logic [15:0] probe2p5;
    logic [15:0] probe7p5;
    logic [15:0] sig5;
    logic [15:0] probe32p5;
    logic [15:0] probe42p5;
    logic [15:0] sig37p5;
  } fnf_amp_t;
  // qualifier settings; time limit in tenths of a second
  typedef struct packed {
    logic [6:0] count;
    logic [6:0] pct;
    logic [11:0] tlim;
  } fnf_cfg_t;
  typedef enum logic {FNF_RATE_LOW, FNF_RATE_HIGH} fnf_rate_t;
  typedef enum {FNF_IDLE, FNF_EVAL, FNF_PUBLISH} fnf_state_t;
endpackage
`default_nettype wire

// ---- core/fnf_regs.svh ----
`ifndef FNF_REGS_SVH
`define FNF_REGS_SVH
// register numbers on the host port
`define FNF_REG_COIL 9'h04d
`define FNF_REG_ENABLE 9'h04e
`define FNF_REG_MODE 9'h04f
`define FNF_REG_SAMPLES 9'h050
`define FNF_REG_AUTOZERO 9'h06e
`define FNF_REG_PCT_HI 9'h169
`define FNF_REG_PCT_LO 9'h16a
`define FNF_REG_TLIM_HI 9'h16b
`define FNF_REG_TLIM_LO 9'h16c
// field positions
`define FNF_BIT_ON 0
// reset and factory default values, setting limits and scale factors
`define FNF_SAMPLES_DEF 7'h5a
`define FNF_SAMPLES_MIN 7'h01
`define FNF_SAMPLES_MAX 7'h7d
`define FNF_PCT_DEF 7'h02
`define FNF_PCT_MAX 7'h64
`define FNF_TLIM_DEF 12'h014
`define FNF_TLIM_MIN 12'h006
`define FNF_TLIM_MAX 12'ha00
`define FNF_NOISE_RATIO 24'h00_0019
`define FNF_PCT_DIV 40'h00_0000_0064
// timing: clock rate, sample increment in ms, auto-zero in s
`define FNF_CLK_HZ 64'h0000_0000_017d_7840
`define FNF_TICK_MS 64'h0000_0000_0000_0064
`define FNF_AZ_S 64'h0000_0000_0000_005a
`define FNF_TICK_CYCLES (`FNF_CLK_HZ / 64'h0000_0000_0000_03e8 * `FNF_TICK_MS)
`define FNF_AZ_CYCLES (`FNF_CLK_HZ * `FNF_AZ_S)
`endif

// ---- verification/fnf_host_model.sv ----
`include "fnf_regs.svh"
`default_nettype none
module fnf_host_model (
  input wire logic clock,
  output logic regWrite,
  output logic regRead,
  output logic [8:0] regAddr,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic regRvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle host at time zero
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = '0;
    regWdata = '0;
  end
  // one write, taken at the edge after raising the strobe
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // one read; answer stands for the cycle after the taking edge
  task automatic rd(input logic [8:0] a, output logic [16:0] q);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
    q = {regRvalid, regRdata};
  endtask
  // zeroing only ever requested at the high rate
  task automatic az();
    wr(`FNF_REG_COIL, 16'h0001);
    wr(`FNF_REG_AUTOZERO, 16'h0001);
  endtask
endmodule
`default_nettype wire

// ---- verification/fnf_monitor.sv ----
`include "fnf_regs.svh"
`default_nettype none
module fnf_monitor
  import fnf_pkg::*;
#(
  parameter logic [31:0] AZ_CYCLES = 32'h0000_0032
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [8:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regRvalid,
  input wire fnf_amp_t amp,
  input wire logic ampValid,
  input wire logic flowOutValid,
  input wire logic highNoise,
  input wire logic coilRateHigh,
  input wire logic autoZeroBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // verdict for the band in use; doubled signal avoids a divide
  logic noisy;
  always_comb begin
    if (coilRateHigh) begin
      noisy = 32'(amp.sig37p5) * 32'h2 < (32'(amp.probe32p5) + 32'(amp.probe42p5)) * 32'h19;
    end else begin
      noisy = 32'(amp.sig5) * 32'h2 < (32'(amp.probe2p5) + 32'(amp.probe7p5)) * 32'h19;
    end
  end
  // cycles spent busy so far
  logic [31:0] busyLen;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busyLen <= '0;
    end else begin
      busyLen <= autoZeroBusy ? busyLen + 32'h1 : '0;
    end
  end
  logic rateWr;
  assign rateWr = regWrite && (regAddr == `FNF_REG_COIL || regAddr == `FNF_REG_MODE);
  property p_rvalid; regRead |=> regRvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_rquiet; !regRead |=> !regRvalid; endproperty
  a_rquiet: assert property (p_rquiet) else $error("stray read valid");
  property p_noise; ampValid && !regWrite |=> highNoise == $past(noisy); endproperty
  a_noise: assert property (p_noise) else $error("noise flag wrong");
  property p_hold; !ampValid |=> $stable(highNoise); endproperty
  a_hold: assert property (p_hold) else $error("noise flag moved");
  property p_pulse; flowOutValid |=> !flowOutValid [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("outputs too close");
  property p_filter; regWrite && regAddr == `FNF_REG_MODE && regWdata[0] |=> coilRateHigh;
  endproperty
  a_filter: assert property (p_filter) else $error("filter mode left rate low");
  property p_low; regWrite && regAddr == `FNF_REG_COIL && !regWdata[0] |=> !coilRateHigh;
  endproperty
  a_low: assert property (p_low) else $error("rate not lowered");
  property p_rate; !rateWr |=> $stable(coilRateHigh); endproperty
  a_rate: assert property (p_rate) else $error("rate changed alone");
  property p_azgo;
    regWrite && regAddr == `FNF_REG_AUTOZERO && regWdata[0] && !autoZeroBusy |=> autoZeroBusy;
  endproperty
  a_azgo: assert property (p_azgo) else $error("auto-zero not started");
  property p_azlen;
    $fell(autoZeroBusy) |-> busyLen + 32'h2 >= AZ_CYCLES && busyLen <= AZ_CYCLES + 32'h2;
  endproperty
  a_azlen: assert property (p_azlen) else $error("auto-zero length wrong");
  c_out: cover property (flowOutValid);
  c_noisy: cover property (ampValid && noisy);
  c_az: cover property ($fell(autoZeroBusy));
endmodule
bind flow_noise_filter fnf_monitor #(.AZ_CYCLES(AZ_CYCLES)) monitor (.clock(clock), .rst(rst),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
  .regRvalid(regRvalid), .amp(amp), .ampValid(ampValid), .flowOutValid(flowOutValid),
  .highNoise(highNoise), .coilRateHigh(coilRateHigh), .autoZeroBusy(autoZeroBusy));
`default_nettype wire

// ---- verification/testbench.sv ----
`include "fnf_regs.svh"
`default_nettype none
module testbench import fnf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [8:0] a; logic [15:0] d; logic [8:0] r;
    logic [15:0] e;} fnf_row_t;
  logic clock = 1'b0, rst = 1'b1, regWrite, regRead, regRvalid, sampleValid = 1'b0;
  logic sampleReady, ampValid = 1'b0, flowOutValid, highNoise, coilRateHigh, autoZeroBusy;
  logic [8:0] regAddr;
  logic [15:0] regWdata, regRdata;
  logic [16:0] q;
  fnf_flow_t sampleIn = '0, flowOut;
  fnf_amp_t amp = '0;
  int errors = 0, check_count = 0, k, n;
  // write flag, write place and data, read place, expected readback
  fnf_row_t rows[24] = '{'{0,'h050,0,'h050,'h5a}, '{0,0,0,'h16a,'h02}, '{0,0,0,'h16c,'h14},
    '{0,0,0,'h04f,0}, '{1,'h050,'h7d,'h050,'h7d}, '{1,'h050,'h7e,'h050,'h7d},
    '{1,'h050,0,'h050,'h7d}, '{1,'h050,1,'h050,1}, '{1,'h16a,'h65,'h16a,'h02},
    '{1,'h16a,'h64,'h16a,'h64}, '{1,'h16c,5,'h16c,'h14}, '{1,'h16c,'ha01,'h16c,'h14},
    '{1,'h16c,'ha00,'h16c,'ha00}, '{1,'h16c,6,'h16c,6}, '{1,'h169,7,'h169,0},
    '{1,'h100,3,'h100,0}, '{1,'h04f,1,'h050,'h5a}, '{0,0,0,'h16a,'h02}, '{0,0,0,'h04d,1},
    '{0,0,0,'h04e,1}, '{1,'h04e,0,'h04f,0}, '{1,'h04f,1,'h04f,1}, '{1,'h04d,0,'h04f,0},
    '{0,0,0,'h06e,0}};
  int flowIn[10] = '{'h3e8, 'h3e8, 'h7d0, 'h3e8, 'h7d0, 'h7d0, 'h7d0, 'h7d0, 'h7d0, 'h7d0};
  int flowExp[10] = '{'h3e8, 'h3e8, 'h3e8, 'h3e8, 'h3e8, 'h4e2, 'h578, 'h5dc, -1, 'h7d0};
  always #20 clock = ~clock;
  flow_noise_filter #(.TICK_CYCLES(32'h0000_0014), .AZ_CYCLES(32'h0000_0032)) DUT (
    .clock(clock), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid), .sampleIn(sampleIn),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .amp(amp), .ampValid(ampValid),
    .flowOut(flowOut), .flowOutValid(flowOutValid), .highNoise(highNoise),
    .coilRateHigh(coilRateHigh), .autoZeroBusy(autoZeroBusy));
  fnf_host_model host (.clock(clock), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a wait that ran out ends the run
  task automatic spent();
    errors++;
    summarize();
  endtask
  // next published flow value; own counter, as it runs beside the pusher
  task automatic next_out();
    int t;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (!flowOutValid && t < 300);
    if (!flowOutValid) spent();
  endtask
  // offer one sample and hold it until the buffer takes it
  task automatic push(input fnf_flow_t v);
    int t;
    sampleValid <= 1'b1;
    sampleIn <= v;
    t = 0;
    do begin
      @(posedge clock);
      if (!sampleReady) n = 1;
      t++;
    end while (!sampleReady && t < 500);
    if (!sampleReady) spent();
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk({flowOut, flowOutValid, highNoise, coilRateHigh, autoZeroBusy, sampleReady}, 37'h1);
    foreach (rows[i]) begin
      if (rows[i].w) host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].r, q);
      chk(32'(q), {15'h0, 1'b1, rows[i].e});
    end
    // filter mode, wide window, 10 percent band, 0.6 s limit
    host.wr(`FNF_REG_MODE, 16'h0001);
    host.wr(`FNF_REG_SAMPLES, 16'h007d);
    host.wr(`FNF_REG_PCT_LO, 16'h000a);
    host.wr(`FNF_REG_TLIM_LO, 16'h0006);
    repeat (30) @(posedge clock);
    n = 0;
    fork
      begin
        // push until the buffer refuses, then wait for room
        foreach (flowIn[i]) push(flowIn[i]);
        sampleValid <= 1'b0;
      end
      for (int i = 0; i < 10; i++) begin
        next_out();
        if (flowExp[i] != -1) chk(flowOut, flowExp[i]);
      end
    join
    chk(n, 1);
    // processing off: raw value passes straight through
    host.wr(`FNF_REG_ENABLE, 16'h0000);
    repeat (30) @(posedge clock);
    push(32'h0000_0309);
    sampleValid <= 1'b0;
    next_out();
    chk(flowOut, 32'h0000_0309);
    // each band, failing then passing by one count; the other band is always bad
    for (int r = 0; r < 2; r++) begin
      for (int d = 1; d >= 0; d--) begin
        host.wr(`FNF_REG_COIL, 16'(r));
        @(posedge clock);
        amp <= '{16'h4, 16'h6, r ? 16'h1 : 16'(125 - d), 16'h4, 16'h6, r ? 16'(125 - d) : 16'h1};
        ampValid <= 1'b1;
        @(posedge clock);
        ampValid <= 1'b0;
        @(negedge clock);
        chk(highNoise, d);
      end
    end
    host.az();
    k = 0;
    n = 0;
    do begin
      @(posedge clock);
      k++;
      if (autoZeroBusy) n++;
    end while ((n == 0 || autoZeroBusy) && k < 200);
    if (n == 0 || autoZeroBusy) spent();
    chk(n >= 48 && n <= 52, 1);
    // reset mid-run: rate and count go back to their power-up values
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    host.rd(`FNF_REG_SAMPLES, q);
    chk({coilRateHigh, autoZeroBusy, 32'(q)}, 34'h0_0001_005a);
    summarize();
  end
endmodule
`default_nettype wire
